// ===== bench/pll_calibration_timing_config_test.sv
/*
 * Self-checking bench for the calibration timing block: register port,
 * reset values and the waits of the calibration sequence.
 * Assumes the package and design files under src/ are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

module pll_calibration_timing_config_test import pll_cal_pkg::*;;
	typedef struct {int k; int lo; int hi;} note_t;
	localparam int LIMIT = 60000;
	logic clock = 1'b0;
	logic rst_b = 1'b0;
	reg_req_t reg_req = '0;
	logic cal_start = 1'b0;
	logic cal_bypass = 1'b0;
	logic coarse_done = 1'b0;
	logic fine_done = 1'b0;
	logic ref_tick = 1'b0;
	logic pfd_tick = 1'b0;
	logic rdv = 1'b0;
	logic rdv_d = 1'b0;
	logic [15:0] rdata;
	logic ref_buf_diff;
	logic [15:0] v;
	seq_out_t so;
	seq_out_t prv = '0;
	logic [5:0] watch = '0;
	logic [5:0] ev;
	logic [15:0] rq[$];
	note_t eq[$];
	note_t n;
	int cyc = 0;
	int last = 0;
	int d = 0;
	int fails = 0;
	int cmp_count = 0;

	always #2.5 clock = ~clock;

	// arbitrary revision value
	pll_cal_timing #(.REV_ID(8'h5A)) dut (
		.CLOCK(clock), .RST_B(rst_b), .REG_REQ(reg_req),
		.REG_RDATA(rdata), .CAL_START(cal_start),
		.CAL_BYPASS(cal_bypass), .COARSE_DONE(coarse_done),
		.FINE_DONE(fine_done), .REF_TICK(ref_tick),
		.PFD_TICK(pfd_tick), .SEQ_OUT(so), .REF_BUF_DIFF(ref_buf_diff)
	);

	// one bit per watched event, in note kind order
	assign ev = watch & {!so.ssm_clk_en && prv.ssm_clk_en,
		so.lock && !prv.lock, so.fine_step, so.coarse_step,
		so.peak_en && !prv.peak_en, so.vtune_en && !prv.vtune_en};

	// ====================
	// checks and bus tasks
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		cmp_count++;
		if (s !== e) begin
			fails++;
			$display("wrong value at %0t: seen %h expected %h", $time, s, e);
		end
	endtask

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] dat);
		@(posedge clock);
		reg_req <= '{wr: 1'b1, addr: a, wdata: dat};
		@(posedge clock);
		reg_req.wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		@(posedge clock);
		reg_req <= '{wr: 1'b0, addr: a, wdata: 16'h0000};
		rq.push_back(e);
		rdv <= 1'b1;
		@(posedge clock);
		rdv <= 1'b0;
	endtask

	task automatic nt(input int k, input int lo, input int hi);
		eq.push_back('{k, lo, hi});
	endtask

	task automatic waitev(input int k);
		do @(posedge clock); while (!ev[k]);
	endtask

	task automatic pulse_start(input logic first);
		@(posedge clock);
		cal_start <= 1'b1;
		if (first) begin
			last = cyc;
		end
		@(posedge clock);
		cal_start <= 1'b0;
	endtask

	// ====================
	// one calibration run
	// windows allow for the free running digital tick phase
	task automatic run(input logic [2:0] code, input logic byp);
		int lo;
		int hi;
		int sh;
		@(posedge clock);
		rst_b <= 1'b0;
		watch <= '0;
		repeat (2) @(posedge clock);
		rst_b <= 1'b1;
		wr(8'h10, 16'h0821);
		wr(8'h11, 16'h0841 | {5'h00, code, 8'h00});
		coarse_done <= 1'b0;
		fine_done <= 1'b0;
		cal_bypass <= byp;
		watch <= byp ? 6'h30 : 6'h3F;
		sh = (code > 3'd3) ? 3 : int'(code);
		lo = (128 << sh) - 4 + 120;
		hi = (128 << sh) + 3 + 163;
		if (!byp) begin
			nt(0, 1, 3);
			nt(1, 2520, 2563);
			nt(2, 120, 163);
			nt(2, 120, 163);
			nt(3, 368, 422);
			nt(3, 248, 259);
			lo += 248;
			hi += 259;
		end
		nt(4, lo, hi);
		nt(5, 2520, 2563);
		pulse_start(1'b1);
		if (!byp) begin
			waitev(0);
			chk(16'({so.busy, so.vtune_en, so.peak_en}), 16'h0006);
			wr(8'h10, 16'h0822);
			repeat (100) @(posedge clock);
			// refused while running, so the timing base stays put
			pulse_start(1'b0);
			waitev(2);
			waitev(2);
			coarse_done <= 1'b1;
			waitev(3);
			waitev(3);
			fine_done <= 1'b1;
		end
		waitev(5);
		repeat (4) @(posedge clock);
		chk(16'(eq.size()), 16'h0000);
		chk(16'({so.busy, so.lock, so.ssm_clk_en, so.vtune_en, so.peak_en}),
			16'h0008);
	endtask

	// ====================
	// monitor
	always @(posedge clock) begin
		cyc <= cyc + 1;
		prv <= so;
		rdv_d <= rdv;
		ref_tick <= (cyc % 8 == 7);
		pfd_tick <= (cyc % 4 == 1);
		if (rdv_d) begin
			chk(rdata, rq.pop_front());
		end
		for (int k = 0; k < 6; k++) begin
			if (ev[k]) begin
				if (eq.size() > 0) begin
					n = eq.pop_front();
				end else begin
					n = '{-1, 0, 0};
				end
				d = cyc - last;
				last = cyc;
				chk(16'(k), 16'(n.k));
				chk((d >= n.lo && d <= n.hi) ? 16'(n.lo) : 16'(d), 16'(n.lo));
			end
		end
	end

	// hang guard, well above the longest run
	always @(posedge clock) begin
		if (cyc == LIMIT) begin
			fails++;
			give_verdict();
		end
	end

	// ====================
	// main sequence
	initial begin
		void'($urandom(44));
		repeat (4) @(posedge clock);
		rst_b <= 1'b1;
		rd(8'h10, 16'h921F);
		rd(8'h11, 16'h06C4);
		rd(8'h1A, 16'h0B14);
		rd(8'h18, 16'h065A);
		rd(8'h33, 16'h0000);
		chk(ref_buf_diff, 1'b0);
		for (int i = 0; i < 4; i++) begin
			v = {i[0], 15'($urandom)};
			wr(8'h10, v);
			wr(8'h11, ~v);
			wr(8'h1A, v);
			wr(8'h18, v);
			wr(8'h33, v);
			rd(8'h10, v);
			rd(8'h11, ~v);
			rd(8'h1A, v);
			rd(8'h18, 16'h065A);
			rd(8'h33, 16'h0000);
			chk(ref_buf_diff, v[15]);
		end
		run(3'd1, 1'b0);
		for (int c = 0; c < 5; c++) begin
			run((c < 4) ? c[2:0] : 3'd6, 1'b1);
		end
		repeat (4) @(posedge clock);
		give_verdict();
	end
endmodule

`default_nettype wire

// ===== src/pll_cal_defs.svh
/*
 * Constants of the calibration timing block: register offsets, field
 * positions, reset values and timing counts.
 * Assumes inclusion by bare name from files under src/.
 */
`ifndef PLL_CAL_DEFS_SVH
`define PLL_CAL_DEFS_SVH

// ==========================================================
// register offsets
`define OFF_STARTUP_A 8'h10
`define OFF_STARTUP_B 8'h11
`define OFF_REVISION 8'h18
`define OFF_INPUT_BUF 8'h1A

// ==========================================================
// reset values
`define RST_STARTUP_A 16'h921F
`define RST_STARTUP_B 16'h06C4
`define RST_INPUT_BUF 16'h0B14
`define REV_RSVD_VAL 8'h06

// ==========================================================
// field positions
`define LOCK_DLY_MSB 15
`define LOCK_DLY_LSB 11
`define INIT_SETTLE_MSB 10
`define INIT_SETTLE_LSB 5
`define PUMP_WAIT_MSB 4
`define PUMP_WAIT_LSB 0
`define SWITCH_MSB 14
`define SWITCH_LSB 11
`define LOCK_CNT_MSB 10
`define LOCK_CNT_LSB 8
`define FINE_SETTLE_MSB 7
`define FINE_SETTLE_LSB 6
`define COARSE_STEP_MSB 5
`define COARSE_STEP_LSB 0
`define REF_BUF_BIT 15

// ==========================================================
// timing
`define CLOCK_PERIOD_NS 5
`define DIG_PERIOD_NS 200
`define DIG_DIV_CYCLES (`DIG_PERIOD_NS / `CLOCK_PERIOD_NS)
`define PUMP_SCALE_SH 6
`define INIT_SCALE_SH 2
`define COARSE_SCALE_SH 2
`define FINE_SCALE_SH 5
`define LOCK_DLY_SCALE_SH 2
`define SWITCH_SCALE_SH 6
`define LOCK_CNT_BASE_SH 5
`define LOCK_CNT_MAX_CODE 3
`define CNT_W 12

`endif

// ===== src/pll_cal_pkg.sv
/*
 * Types of the calibration timing block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package pll_cal_pkg;

	// ==========================================================
	// sequencer states
	typedef enum logic [3:0] {
		ST_IDLE,
		ST_PUMP_WAIT,
		ST_INIT_SETTLE,
		ST_COARSE,
		ST_FINE,
		ST_LOCK_COUNT,
		ST_LOCK_DELAY,
		ST_HOLD,
		ST_SLEEP
	} seq_state_t;

	// ==========================================================
	// carriers
	typedef struct packed {
		logic wr;
		logic [7:0] addr;
		logic [15:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic vtune_en;
		logic peak_en;
		logic coarse_step;
		logic fine_step;
		logic lock;
		logic ssm_clk_en;
		logic busy;
	} seq_out_t;

endpackage

// ===== src/pll_cal_timing.sv
/*
 * Calibration timing sequencer with its configuration registers.
 * Assumes a register port already decoded from the serial interface,
 * and reference and pfd ticks given as one-cycle pulses on CLOCK.
 */
// Overview of operation
// - after calibration, lock stays low 4 x lock_dly digital ticks, then rises
// - peak enable to first coarse change waits 4 x init settle ticks
// - peak enable rises 64 x pump field ticks after vtune enable
// - after lock rises, wait switch x 64 ticks, then stop clock
// - lock waits 32, 64, 128 or 256 pfd ticks by lock-count code
// - successive fine cap codes are 32 x fine field reference ticks apart
// - successive coarse changes are 4 x coarse field ticks apart
// - read-only revision: low byte revision id, high byte fixed value
// - input buffer bit 15 selects cmos or ac differential reference
// - without bypass, a coarse round runs first, then a fine round
`timescale 1ns/1ps
`default_nettype none
`include "pll_cal_defs.svh"

module pll_cal_timing import pll_cal_pkg::*; #(
	// arbitrary value
	parameter logic [7:0] REV_ID = 8'h3C
) (
	// clock and reset
	input wire logic CLOCK,
	input wire logic RST_B,
	// register port
	input wire reg_req_t REG_REQ,
	output logic [15:0] REG_RDATA,
	// sequencer control
	input wire logic CAL_START,
	input wire logic CAL_BYPASS,
	input wire logic COARSE_DONE,
	input wire logic FINE_DONE,
	input wire logic REF_TICK,
	input wire logic PFD_TICK,
	// sequencer outputs and reference buffer select
	output seq_out_t SEQ_OUT,
	output logic REF_BUF_DIFF
);
	// ==========================================================
	// registers
	logic [15:0] cfg_a_reg;
	logic [15:0] cfg_b_reg;
	logic [15:0] in_buf_reg;
	logic [15:0] rdata_next;

	wire hit_a = (REG_REQ.addr == `OFF_STARTUP_A);
	wire hit_b = (REG_REQ.addr == `OFF_STARTUP_B);
	wire hit_rev = (REG_REQ.addr == `OFF_REVISION);
	wire hit_buf = (REG_REQ.addr == `OFF_INPUT_BUF);
	wire [15:0] rev_word = {`REV_RSVD_VAL, REV_ID};

	assign rdata_next = hit_a ? cfg_a_reg :
		hit_b ? cfg_b_reg :
		hit_rev ? rev_word :
		hit_buf ? in_buf_reg : 16'h0000;

	// revision offset ignores writes; unmapped reads give zero
	always_ff @(posedge CLOCK) begin
		if (!RST_B) begin
			cfg_a_reg <= `RST_STARTUP_A;
			cfg_b_reg <= `RST_STARTUP_B;
			in_buf_reg <= `RST_INPUT_BUF;
			REG_RDATA <= 16'h0000;
		end else begin
			if (REG_REQ.wr && hit_a)
				cfg_a_reg <= REG_REQ.wdata;
			if (REG_REQ.wr && hit_b)
				cfg_b_reg <= REG_REQ.wdata;
			if (REG_REQ.wr && hit_buf)
				in_buf_reg <= REG_REQ.wdata;
			REG_RDATA <= rdata_next;
		end
	end

	assign REF_BUF_DIFF = in_buf_reg[`REF_BUF_BIT];

	// ==========================================================
	// fields
	wire [4:0] f_lock_dly = cfg_a_reg[`LOCK_DLY_MSB:`LOCK_DLY_LSB];
	wire [5:0] f_init = cfg_a_reg[`INIT_SETTLE_MSB:`INIT_SETTLE_LSB];
	wire [4:0] f_pump = cfg_a_reg[`PUMP_WAIT_MSB:`PUMP_WAIT_LSB];
	wire [3:0] f_switch = cfg_b_reg[`SWITCH_MSB:`SWITCH_LSB];
	wire [2:0] f_lock_cnt = cfg_b_reg[`LOCK_CNT_MSB:`LOCK_CNT_LSB];
	wire [1:0] f_fine = cfg_b_reg[`FINE_SETTLE_MSB:`FINE_SETTLE_LSB];
	wire [5:0] f_coarse = cfg_b_reg[`COARSE_STEP_MSB:`COARSE_STEP_LSB];

	// lock count decode
	// codes above 3 saturate at the longest wait
	function automatic logic [`CNT_W-1:0] lock_cycles(input logic [2:0] code);
		logic [2:0] c;
		c = (code > 3'(`LOCK_CNT_MAX_CODE)) ? 3'(`LOCK_CNT_MAX_CODE) : code;
		lock_cycles = `CNT_W'(1) << (`LOCK_CNT_BASE_SH + c);
	endfunction

	function automatic logic [`CNT_W-1:0] step_len(input seq_state_t st);
		step_len = '0;
		unique case (st)
			ST_PUMP_WAIT: step_len = `CNT_W'(f_pump) << `PUMP_SCALE_SH;
			ST_INIT_SETTLE: step_len = `CNT_W'(f_init) << `INIT_SCALE_SH;
			ST_COARSE: step_len = `CNT_W'(f_coarse) << `COARSE_SCALE_SH;
			ST_FINE: step_len = `CNT_W'(f_fine) << `FINE_SCALE_SH;
			ST_LOCK_COUNT: step_len = lock_cycles(f_lock_cnt);
			ST_LOCK_DELAY: step_len = `CNT_W'(f_lock_dly) << `LOCK_DLY_SCALE_SH;
			ST_HOLD: step_len = `CNT_W'(f_switch) << `SWITCH_SCALE_SH;
			ST_IDLE, ST_SLEEP: step_len = '0;
		endcase
	endfunction

	// ==========================================================
	// digital clock divider
	logic [5:0] div_reg;
	wire dig_tick = (div_reg == 6'(`DIG_DIV_CYCLES - 1));

	always_ff @(posedge CLOCK) begin
		if (!RST_B)
			div_reg <= 6'h00;
		else
			div_reg <= dig_tick ? 6'h00 : div_reg + 6'h01;
	end

	// ==========================================================
	// sequencer
	seq_state_t state_reg;
	seq_state_t state_next;
	logic load;
	logic coarse_pulse;
	logic fine_pulse;
	logic done;
	logic tick_cur;
	wire [`CNT_W-1:0] load_val = step_len(state_next);

	assign tick_cur = (state_reg == ST_FINE) ? REF_TICK :
		(state_reg == ST_LOCK_COUNT) ? PFD_TICK : dig_tick;

	always_comb begin
		state_next = state_reg;
		load = 1'b0;
		coarse_pulse = 1'b0;
		fine_pulse = 1'b0;
		unique case (state_reg)
			ST_IDLE, ST_SLEEP: begin
				if (CAL_START) begin
					state_next = CAL_BYPASS ? ST_LOCK_COUNT : ST_PUMP_WAIT;
					load = 1'b1;
				end
			end
			ST_PUMP_WAIT: begin
				if (done) begin
					state_next = ST_INIT_SETTLE;
					load = 1'b1;
				end
			end
			ST_INIT_SETTLE: begin
				if (done) begin
					state_next = ST_COARSE;
					load = 1'b1;
					coarse_pulse = 1'b1;
				end
			end
			ST_COARSE: begin
				if (done) begin
					load = 1'b1;
					if (COARSE_DONE)
						state_next = ST_FINE;
					else
						coarse_pulse = 1'b1;
				end
			end
			ST_FINE: begin
				if (done) begin
					load = 1'b1;
					if (FINE_DONE)
						state_next = ST_LOCK_COUNT;
					else
						fine_pulse = 1'b1;
				end
			end
			ST_LOCK_COUNT: begin
				if (done) begin
					state_next = ST_LOCK_DELAY;
					load = 1'b1;
				end
			end
			ST_LOCK_DELAY: begin
				if (done) begin
					state_next = ST_HOLD;
					load = 1'b1;
				end
			end
			ST_HOLD: begin
				if (done)
					state_next = ST_SLEEP;
			end
			default: state_next = ST_IDLE;
		endcase
	end

	step_delay_counter u_wait (
		.clock(CLOCK),
		.rst_b(RST_B),
		.load(load),
		.load_val(load_val),
		.tick(tick_cur),
		.done(done)
	);

	// ==========================================================
	// outputs
	// registered from the next state so they line up with state_reg
	seq_out_t out_next;
	wire nx_cal = (state_next == ST_PUMP_WAIT) ||
		(state_next == ST_INIT_SETTLE) || (state_next == ST_COARSE) ||
		(state_next == ST_FINE);
	wire nx_lock = (state_next == ST_HOLD) || (state_next == ST_SLEEP);
	wire nx_idle = (state_next == ST_IDLE) || nx_lock;

	assign out_next.vtune_en = nx_cal;
	assign out_next.peak_en = nx_cal && (state_next != ST_PUMP_WAIT);
	assign out_next.coarse_step = coarse_pulse;
	assign out_next.fine_step = fine_pulse;
	assign out_next.lock = nx_lock;
	assign out_next.ssm_clk_en = (state_next != ST_SLEEP);
	assign out_next.busy = !nx_idle;

	always_ff @(posedge CLOCK) begin
		if (!RST_B) begin
			state_reg <= ST_IDLE;
			SEQ_OUT <= '{ssm_clk_en: 1'b1, default: 1'b0};
		end else begin
			state_reg <= state_next;
			SEQ_OUT <= out_next;
		end
	end

	// ==========================================================
	// checks
	logic [`CNT_W-1:0] seen_reg;
	logic [`CNT_W-1:0] exp_reg;

	always_ff @(posedge CLOCK) begin
		if (!RST_B) begin
			seen_reg <= '0;
			exp_reg <= '0;
		end else if (load) begin
			seen_reg <= '0;
			exp_reg <= load_val;
		end else if (tick_cur && !done) begin
			seen_reg <= seen_reg + 1'b1;
		end
	end

	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RST_B);

	AST_LOCK_DELAY: assert property (
		(load && state_next == ST_LOCK_DELAY) |=>
		exp_reg == (`CNT_W'($past(f_lock_dly)) << 2) ##0
		(!SEQ_OUT.lock throughout (state_reg == ST_LOCK_DELAY)))
		else $error("lock delay load or lock level wrong");
	AST_INIT_SETTLE: assert property (
		(load && state_next == ST_INIT_SETTLE) |=>
		exp_reg == (`CNT_W'($past(f_init)) << 2))
		else $error("initial settle length wrong");
	AST_PUMP_WAIT: assert property (
		(state_reg == ST_PUMP_WAIT && done) |=>
		$rose(SEQ_OUT.peak_en) && SEQ_OUT.vtune_en)
		else $error("peak enable did not follow pump wait");
	AST_SWITCH_OFF: assert property (
		(state_reg == ST_HOLD && done) |->
		!SEQ_OUT.vtune_en && !SEQ_OUT.peak_en ##1
		!SEQ_OUT.ssm_clk_en && SEQ_OUT.lock)
		else $error("sequencer clock stop wrong");
	AST_LOCK_COUNT: assert property (
		(load && state_next == ST_LOCK_COUNT) |=>
		exp_reg == (($past(f_lock_cnt) > 3'h3) ? 12'h100 :
		(12'h020 << $past(f_lock_cnt))))
		else $error("lock count decode wrong");
	AST_FINE_SETTLE: assert property (
		(load && state_next == ST_FINE) |=>
		exp_reg == (`CNT_W'($past(f_fine)) << 5))
		else $error("fine settle length wrong");
	AST_COARSE_STEP: assert property (
		(load && state_next == ST_COARSE) |=>
		exp_reg == (`CNT_W'($past(f_coarse)) << 2))
		else $error("coarse step length wrong");
	AST_REVISION: assert property (
		hit_rev |=> REG_RDATA == {8'h06, REV_ID})
		else $error("revision read wrong");
	AST_REF_BUF: assert property (
		(REG_REQ.wr && hit_buf) |=>
		REF_BUF_DIFF == $past(REG_REQ.wdata[15]))
		else $error("buffer select not updated");
	AST_ROUND_ORDER: assert property (
		(state_reg == ST_FINE && $past(state_reg) != ST_FINE) |->
		$past(state_reg) == ST_COARSE)
		else $error("fine round not after coarse round");
	AST_WAIT_COUNT: assert property (
		done |-> seen_reg == exp_reg)
		else $error("wait length differs from loaded field");

	COV_BYPASS: cover property (
		(state_reg == ST_IDLE && CAL_START && CAL_BYPASS) ##1
		state_reg == ST_LOCK_COUNT);
	COV_COARSE_STEPS: cover property (
		SEQ_OUT.coarse_step ##[1:300] SEQ_OUT.coarse_step);
	COV_FINE_STEP: cover property (SEQ_OUT.fine_step);
	COV_SLEEP: cover property ($fell(SEQ_OUT.ssm_clk_en));

endmodule
`default_nettype wire

// ===== src/step_delay_counter.sv
/*
 * Down counter for one sequencer wait: loads a length, counts enable
 * ticks, flags the end for one cycle.
 * Assumes load and tick are synchronous to clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pll_cal_defs.svh"

module step_delay_counter (
	// clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// control
	input wire logic load,
	input wire logic [`CNT_W-1:0] load_val,
	input wire logic tick,
	// status
	output logic done
);
	logic [`CNT_W-1:0] cnt_reg;
	logic run_reg;
	wire at_zero = (cnt_reg == '0);

	// ==========================================================
	// counter
	// a zero length still ends one cycle after the load
	assign done = run_reg && at_zero;

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			cnt_reg <= '0;
			run_reg <= 1'b0;
		end else if (load) begin
			cnt_reg <= load_val;
			run_reg <= 1'b1;
		end else if (done) begin
			run_reg <= 1'b0;
		end else if (run_reg && tick) begin
			cnt_reg <= cnt_reg - 1'b1;
		end
	end

endmodule
`default_nettype wire
